// ### dv/hgfbm_board.sv
// Board-side model: local drivers meeting the pads of the hub GPIO block
`timescale 1ns/10ps
`default_nettype none
module hgfbm_board (
  input wire logic [7:0] gpio_out,
  input wire logic [7:0] gpio_oe,
  input wire logic [7:0] ext,
  output logic [7:0] pad
);
  // ****************
  // Pad resolution
  // ****************
  // Hub driver wins where enabled; board levels held long, far below sampling
  assign pad = (gpio_oe & gpio_out) | (~gpio_oe & ext);
endmodule
`default_nettype wire

// ### dv/tb_top.sv
// Testbench for the hub GPIO block: register port, pins, forward and back paths
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic sys_clk = 0, arst_n = 0, scl = 1, sda_m = 1, sda_out, sda_oe;
  logic fsync_int = 0, fsync_ext = 0;
  logic [3:0] fwd_tick = 0, bc_tick = 0;
  logic [15:0] fwd_rx = 0, bc_slot_data;
  logic [7:0] ext = 0, pad, gpio_out, gpio_oe, gpio_in_en, gpio_pd_en, rd, eo, ev;
  logic [31:0] seed = 32'h2b;
  logic q[$];
  int n_fail = 0, tests_run = 0, per;
  // Open-drain data wire: master and target both pull low
  wire logic sda_w = sda_m & ~(sda_oe & ~sda_out);
  hgfbm_gpio u_hgfbm_gpio (.sys_clk(sys_clk), .arst_n(arst_n), .scl_in(scl),
    .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe), .gpio_in(pad),
    .gpio_out(gpio_out), .gpio_oe(gpio_oe), .gpio_in_en(gpio_in_en),
    .gpio_pd_en(gpio_pd_en), .fsync_int(fsync_int), .fsync_ext(fsync_ext),
    .fwd_tick(fwd_tick), .fwd_rx(fwd_rx), .bc_tick(bc_tick), .bc_slot_data(bc_slot_data));
  hgfbm_board u_hgfbm_board (.gpio_out(gpio_out), .gpio_oe(gpio_oe), .ext(ext), .pad(pad));
  // ****************
  // Helpers
  // ****************
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  initial begin
    forever #5 sys_clk = ~sys_clk;
  end
  // One third of a bit time; keeps each bus phase four clocks long
  task automatic h();
    repeat (4) @(negedge sys_clk);
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      n_fail++;
    end
  endtask
  task automatic finish_test();
    $display("mismatches %0d of %0d checks", n_fail, tests_run);
    if (n_fail == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Data moves only while the bus clock is low, so no false start or stop
  task automatic bit_io(input logic b, output logic r);
    sda_m = b;
    h();
    scl = 1;
    h();
    r = sda_w;
    scl = 0;
    h();
  endtask
  task automatic st();
    sda_m = 1;
    h();
    scl = 1;
    h();
    sda_m = 0;
    h();
    scl = 0;
    h();
  endtask
  task automatic sp();
    sda_m = 0;
    h();
    scl = 1;
    h();
    sda_m = 1;
    h();
  endtask
  task automatic tx(input logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    chk({7'h0, r}, 8'h00);
  endtask
  task automatic rx(output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(1'b1, r);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    st();
    tx({hgfbm_pkg::I2C_ADDR_DEFAULT, 1'b0});
    tx(a);
    tx(d);
    sp();
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    st();
    tx({hgfbm_pkg::I2C_ADDR_DEFAULT, 1'b0});
    tx(a);
    st();
    tx({hgfbm_pkg::I2C_ADDR_DEFAULT, 1'b1});
    rx(d);
    sp();
  endtask
  task automatic tick_bc();
    bc_tick[0] = 1;
    @(negedge sys_clk);
    bc_tick[0] = 0;
    @(negedge sys_clk);
  endtask
  // A hang ends the run as a mismatch
  initial begin
    repeat (100000) @(posedge sys_clk);
    $display("[FAIL] %0t timeout", $time);
    n_fail++;
    finish_test();
  end
  // ****************
  // Main sequence
  // ****************
  initial begin
    repeat (4) @(negedge sys_clk);
    arst_n = 1;
    h();
    chk(gpio_in_en, 8'hff);
    chk(gpio_pd_en, 8'hf7);
    chk(gpio_oe, 8'h00);
    // Back slots: external sync, pin 2, internal sync, pin 0
    ext = rnd();
    fsync_ext = 1;
    fsync_int = 1;
    wr(hgfbm_pkg::OFF_PORT_SEL, 8'h00);
    wr(hgfbm_pkg::OFF_BC_SEL_LOW, 8'h29);
    wr(hgfbm_pkg::OFF_BC_SEL_HIGH, 8'h08);
    repeat (29) tick_bc();
    chk({4'h0, bc_slot_data[3:0]}, 8'h00);
    tick_bc();
    chk({4'h0, bc_slot_data[3:0]}, {4'h0, ext[0], 1'b1, ext[2], 1'b1});
    rd_reg(8'h00, rd);
    chk(rd, 8'h00);
    wr(hgfbm_pkg::OFF_PIN_LEVEL, 8'h5a);
    rd_reg(hgfbm_pkg::OFF_PIN_LEVEL, rd);
    chk(rd, ext);
    // Inputs off except open-drain pin 3 before any output is enabled
    wr(hgfbm_pkg::OFF_INPUT_EN, 8'hff);
    chk(gpio_in_en, 8'h08);
    rd_reg(hgfbm_pkg::OFF_INPUT_EN, rd);
    chk(rd, 8'hf7);
    wr(hgfbm_pkg::OFF_PULLDOWN, 8'hff);
    chk(gpio_pd_en, 8'h00);
    // Constant source on every pin; pin 3 open drain
    for (int n = 0; n < 8; n++) begin
      rd = rnd();
      ev[n] = rd[0];
      wr(8'(hgfbm_pkg::OFF_OUT_CTL_FIRST + n), {ev[n], 5'h11, 2'b01});
    end
    eo = 8'hf7 | {4'h0, ~ev[3], 3'h0};
    ev[3] = 0;
    chk(gpio_oe, eo);
    chk(gpio_out, ev);
    rd_reg(hgfbm_pkg::OFF_PIN_LEVEL, rd);
    chk(rd, (eo & ev) | (~eo & ext));
    // Forward value port 1 slot 2 onto pin 0, one link: every frame
    wr(hgfbm_pkg::OFF_OUT_CTL_FIRST, 8'h19);
    for (int k = 0; k < 4; k++) begin
      fwd_rx = {rnd(), rnd()};
      q.push_back(fwd_rx[6]);
      fwd_tick[1] = 1;
      @(negedge sys_clk);
      fwd_tick[1] = 0;
      repeat (2) @(negedge sys_clk);
      chk({7'h0, gpio_out[0]}, {7'h0, q.pop_front()});
    end
    // Port 0 slot 0 onto pin 0 under each linked count: 5, 2, 1 frames
    wr(hgfbm_pkg::OFF_OUT_CTL_FIRST, 8'h01);
    for (int c = 2; c >= 0; c--) begin
      wr(hgfbm_pkg::OFF_FWD_COUNT, 8'(c));
      per = (c == 2) ? 5 : c + 1;
      for (int k = 0; k < 10; k++) begin
        fwd_rx = {rnd(), rnd()};
        if (k % per == 0) q.push_back(fwd_rx[0]);
        fwd_tick[0] = 1;
        @(negedge sys_clk);
        fwd_tick[0] = 0;
        @(negedge sys_clk);
        chk({7'h0, gpio_out[0]}, {7'h0, q[$]});
      end
    end
    finish_test();
  end
endmodule
`default_nettype wire

// ### shared/hgfbm_pkg.sv
// Constants, register map and state codes for the hub GPIO forward/back mapping block
// Operation
// - Reset leaves all pins inputs, pulldowns on except pin three
// - Open-drain pin three lacks input and pulldown control
// - Input control register holds one bit per pin
// - Separate register controls each pin's pulldown
// - Level register reads every pin, any direction
// - Per-pin output control; bit zero enables output
// - Four forward values per port, any pin
// - Forward update every 1, 2 or 5 frames
// - Forward latency short, fixed; jitter follows period
// - Frame sync or control drivable on any pin
// - Four back slots per port, any pin
// - Back slots sampled once per thirty-bit frame
// - Back latency and jitter about one frame
// - Internal or external frame sync feeds slots
// - Slot sources set per port, two registers
// - All registers reachable over two-wire target port
package hgfbm_pkg;
  localparam int NUM_PINS = 8;
  localparam int NUM_PORTS = 4;
  localparam int NUM_SLOTS = 4;
  localparam int PIN_IDX_W = 3;
  localparam int PORT_W = 2;
  localparam int SLOT_SEL_W = 4;
  localparam int PIN_OD_IDX = 3;
  // ************************************************************
  // Register offsets
  // ************************************************************
  localparam logic [7:0] OFF_PIN_LEVEL = 8'h0e;
  localparam logic [7:0] OFF_INPUT_EN = 8'h0f;
  localparam logic [7:0] OFF_OUT_CTL_FIRST = 8'h10;
  localparam logic [7:0] OFF_OUT_CTL_LAST = 8'h17;
  localparam logic [7:0] OFF_PORT_SEL = 8'h4c;
  localparam logic [7:0] OFF_FWD_COUNT = 8'h6d;
  localparam logic [7:0] OFF_BC_SEL_LOW = 8'h6e;
  localparam logic [7:0] OFF_BC_SEL_HIGH = 8'h6f;
  localparam logic [7:0] OFF_PULLDOWN = 8'hbe;
  // ************************************************************
  // Reset values and field layout
  // ************************************************************
  localparam logic [7:0] RST_INPUT_DIS = 8'h00;
  localparam logic [7:0] RST_PD_DIS = 8'h00;
  localparam logic [7:0] RST_OUT_CTL = 8'h00;
  localparam logic [15:0] RST_BC_SEL = 16'h0000;
  localparam logic [1:0] RST_FWD_COUNT = 2'h0;
  localparam logic [1:0] RST_PORT_SEL = 2'h0;
  localparam logic [7:0] CTL_MASK = 8'hf7;
  localparam int OUT_EN_BIT = 0;
  localparam int SRC_LSB = 2;
  localparam int SRC_MSB = 6;
  localparam int CONST_BIT = 7;
  localparam logic [4:0] SRC_FWD_LAST = 5'h0f;
  localparam logic [4:0] SRC_FSYNC = 5'h10;
  localparam logic [4:0] SRC_CONST = 5'h11;
  localparam logic [3:0] BC_SRC_PIN_LAST = 4'h7;
  localparam logic [3:0] BC_SRC_INT_FSYNC = 4'h8;
  localparam logic [3:0] BC_SRC_EXT_FSYNC = 4'h9;
  // ************************************************************
  // Timing
  // ************************************************************
  localparam logic [2:0] FWD_PERIOD_ONE = 3'h1;
  localparam logic [2:0] FWD_PERIOD_TWO = 3'h2;
  localparam logic [2:0] FWD_PERIOD_MANY = 3'h5;
  localparam logic [4:0] BC_LAST_BIT = 5'h1d;
  localparam int CLK_PERIOD_NS = 10;
  localparam int FWD_LAT_NS = 225;
  localparam int FWD_LAT_CYC = FWD_LAT_NS / CLK_PERIOD_NS;
  localparam logic [6:0] I2C_ADDR_DEFAULT = 7'h3d;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  typedef enum logic [6:0] {
    HGFBM_IDLE = 7'h01,
    HGFBM_ADDR = 7'h02,
    HGFBM_PTR = 7'h04,
    HGFBM_WDATA = 7'h08,
    HGFBM_ACK = 7'h10,
    HGFBM_RDATA = 7'h20,
    HGFBM_RACK = 7'h40
  } hgfbm_i2c_e;
endpackage

// ### src/hgfbm_gpio.sv
// GPIO pin control, forward value mapping and back slot sampling for the hub
`timescale 1ns/10ps
`default_nettype none
module hgfbm_gpio (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic [7:0] gpio_in,
  output logic [7:0] gpio_out,
  output logic [7:0] gpio_oe,
  output logic [7:0] gpio_in_en,
  output logic [7:0] gpio_pd_en,
  input wire logic fsync_int,
  input wire logic fsync_ext,
  input wire logic [3:0] fwd_tick,
  input wire logic [15:0] fwd_rx,
  input wire logic [3:0] bc_tick,
  output logic [15:0] bc_slot_data
);
  typedef struct packed {
    logic [7:0] in_dis;
    logic [7:0] pd_dis;
    logic [7:0][7:0] out_ctl;
    logic [3:0][15:0] bc_sel;
    logic [3:0][1:0] fwd_cnt;
    logic [1:0] port_sel;
    logic [3:0][2:0] frm;
    logic [15:0] fwd_val;
    logic [3:0][4:0] bcbit;
    logic [15:0] bc_val;
    logic [7:0] pin_lvl;
    logic [7:0] pin_out;
    logic [7:0] pin_oe;
    logic [7:0] in_en_o;
    logic [7:0] pd_en_o;
  } hgfbm_gpio_s;
  hgfbm_gpio_s s_reg;
  hgfbm_gpio_s s_next;
  logic [7:0] reg_raddr;
  logic [7:0] reg_rdata;
  logic reg_wr;
  logic [7:0] reg_waddr;
  logic [7:0] reg_wdata;

  // ************************************************************
  // Helpers
  // ************************************************************

  // Frames between forward updates for a given linked count
  function automatic logic [2:0] fwd_period(input logic [1:0] code);
    logic [2:0] per;
    per = hgfbm_pkg::FWD_PERIOD_MANY;
    if (code == 2'h0) begin
      per = hgfbm_pkg::FWD_PERIOD_ONE;
    end else if (code == 2'h1) begin
      per = hgfbm_pkg::FWD_PERIOD_TWO;
    end
    return per;
  endfunction

  // Value a pin drives for its output control byte
  function automatic logic pin_value(input logic [7:0] ctl, input logic [15:0] fwd,
                                     input logic fs);
    logic [4:0] src;
    logic v;
    src = ctl[hgfbm_pkg::SRC_MSB:hgfbm_pkg::SRC_LSB];
    v = 1'b0;
    if (src <= hgfbm_pkg::SRC_FWD_LAST) begin
      v = fwd[src[3:0]];
    end else if (src == hgfbm_pkg::SRC_FSYNC) begin
      v = fs;
    end else if (src == hgfbm_pkg::SRC_CONST) begin
      v = ctl[hgfbm_pkg::CONST_BIT];
    end
    return v;
  endfunction

  // Value a back slot carries for its source selector
  function automatic logic bc_value(input logic [3:0] sel, input logic [7:0] pins,
                                    input logic fi, input logic fe);
    logic v;
    v = 1'b0;
    if (sel <= hgfbm_pkg::BC_SRC_PIN_LAST) begin
      v = pins[sel[2:0]];
    end else if (sel == hgfbm_pkg::BC_SRC_INT_FSYNC) begin
      v = fi;
    end else if (sel == hgfbm_pkg::BC_SRC_EXT_FSYNC) begin
      v = fe;
    end
    return v;
  endfunction

  // ************************************************************
  // Register access port
  // ************************************************************

  // Host reaches every register through the two-wire target
  hgfbm_i2c_target u_i2c (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .sda_out(sda_out),
    .sda_oe(sda_oe),
    .reg_raddr(reg_raddr),
    .reg_rdata(reg_rdata),
    .reg_wr(reg_wr),
    .reg_waddr(reg_waddr),
    .reg_wdata(reg_wdata)
  );

  // Read mux; paged registers follow the port selector
  always_comb begin
    reg_rdata = 8'h00;
    if (reg_raddr == hgfbm_pkg::OFF_PIN_LEVEL) begin
      reg_rdata = s_reg.pin_lvl;
    end else if (reg_raddr == hgfbm_pkg::OFF_INPUT_EN) begin
      reg_rdata = s_reg.in_dis;
    end else if (reg_raddr >= hgfbm_pkg::OFF_OUT_CTL_FIRST &&
                 reg_raddr <= hgfbm_pkg::OFF_OUT_CTL_LAST) begin
      reg_rdata = s_reg.out_ctl[reg_raddr[hgfbm_pkg::PIN_IDX_W-1:0]];
    end else if (reg_raddr == hgfbm_pkg::OFF_PORT_SEL) begin
      reg_rdata = {6'h00, s_reg.port_sel};
    end else if (reg_raddr == hgfbm_pkg::OFF_FWD_COUNT) begin
      reg_rdata = {6'h00, s_reg.fwd_cnt[s_reg.port_sel]};
    end else if (reg_raddr == hgfbm_pkg::OFF_BC_SEL_LOW) begin
      reg_rdata = s_reg.bc_sel[s_reg.port_sel][7:0];
    end else if (reg_raddr == hgfbm_pkg::OFF_BC_SEL_HIGH) begin
      reg_rdata = s_reg.bc_sel[s_reg.port_sel][15:8];
    end else if (reg_raddr == hgfbm_pkg::OFF_PULLDOWN) begin
      reg_rdata = s_reg.pd_dis;
    end
  end

  // ************************************************************
  // Next-state logic
  // ************************************************************

  // Registers, forward latches, back slot sampling and pin drivers
  always_comb begin
    s_next = s_reg;
    s_next.pin_lvl = gpio_in;
    if (reg_wr) begin
      if (reg_waddr == hgfbm_pkg::OFF_INPUT_EN) begin
        s_next.in_dis = reg_wdata & hgfbm_pkg::CTL_MASK;
      end else if (reg_waddr == hgfbm_pkg::OFF_PULLDOWN) begin
        s_next.pd_dis = reg_wdata & hgfbm_pkg::CTL_MASK;
      end else if (reg_waddr >= hgfbm_pkg::OFF_OUT_CTL_FIRST &&
                   reg_waddr <= hgfbm_pkg::OFF_OUT_CTL_LAST) begin
        s_next.out_ctl[reg_waddr[hgfbm_pkg::PIN_IDX_W-1:0]] = reg_wdata;
      end else if (reg_waddr == hgfbm_pkg::OFF_PORT_SEL) begin
        s_next.port_sel = reg_wdata[hgfbm_pkg::PORT_W-1:0];
      end else if (reg_waddr == hgfbm_pkg::OFF_FWD_COUNT) begin
        s_next.fwd_cnt[s_reg.port_sel] = reg_wdata[1:0];
      end else if (reg_waddr == hgfbm_pkg::OFF_BC_SEL_LOW) begin
        s_next.bc_sel[s_reg.port_sel][7:0] = reg_wdata;
      end else if (reg_waddr == hgfbm_pkg::OFF_BC_SEL_HIGH) begin
        s_next.bc_sel[s_reg.port_sel][15:8] = reg_wdata;
      end
    end
    // Forward values latch only on the frame that opens each sampling period
    for (int p = 0; p < hgfbm_pkg::NUM_PORTS; p++) begin
      if (fwd_tick[p]) begin
        if (s_reg.frm[p] == 3'h0) begin
          s_next.fwd_val[p*4 +: 4] = fwd_rx[p*4 +: 4];
        end
        if (3'(s_reg.frm[p] + 3'h1) >= fwd_period(s_reg.fwd_cnt[p])) begin
          s_next.frm[p] = 3'h0;
        end else begin
          s_next.frm[p] = 3'(s_reg.frm[p] + 3'h1);
        end
      end
    end
    // One sample per thirty-bit back frame; disabled inputs read low
    for (int p = 0; p < hgfbm_pkg::NUM_PORTS; p++) begin
      if (bc_tick[p]) begin
        if (s_reg.bcbit[p] >= hgfbm_pkg::BC_LAST_BIT) begin
          s_next.bcbit[p] = 5'h00;
          for (int k = 0; k < hgfbm_pkg::NUM_SLOTS; k++) begin
            s_next.bc_val[p*4+k] = bc_value(
              s_reg.bc_sel[p][k*4 +: 4], s_reg.pin_lvl & ~s_reg.in_dis,
              fsync_int, fsync_ext);
          end
        end else begin
          s_next.bcbit[p] = 5'(s_reg.bcbit[p] + 5'h01);
        end
      end
    end
    // Pin drivers from next state so a new latch reaches the pin in one edge
    for (int i = 0; i < hgfbm_pkg::NUM_PINS; i++) begin
      if (i == hgfbm_pkg::PIN_OD_IDX) begin
        // Open drain: only pulls low, floats for a high
        s_next.pin_out[i] = 1'b0;
        s_next.pin_oe[i] = s_next.out_ctl[i][hgfbm_pkg::OUT_EN_BIT] &
                           ~pin_value(s_next.out_ctl[i], s_next.fwd_val, fsync_int);
      end else begin
        s_next.pin_out[i] = pin_value(s_next.out_ctl[i], s_next.fwd_val, fsync_int);
        s_next.pin_oe[i] = s_next.out_ctl[i][hgfbm_pkg::OUT_EN_BIT];
      end
    end
    s_next.in_en_o = ~s_next.in_dis;
    s_next.pd_en_o = ~s_next.pd_dis & hgfbm_pkg::CTL_MASK;
  end

  // State register; reset leaves every pin an input, pulldowns on except open-drain pin 3
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_reg <= '0;
      s_reg.in_dis <= hgfbm_pkg::RST_INPUT_DIS;
      s_reg.pd_dis <= hgfbm_pkg::RST_PD_DIS;
      s_reg.out_ctl <= {hgfbm_pkg::NUM_PINS{hgfbm_pkg::RST_OUT_CTL}};
      s_reg.bc_sel <= {hgfbm_pkg::NUM_PORTS{hgfbm_pkg::RST_BC_SEL}};
      s_reg.fwd_cnt <= {hgfbm_pkg::NUM_PORTS{hgfbm_pkg::RST_FWD_COUNT}};
      s_reg.port_sel <= hgfbm_pkg::RST_PORT_SEL;
      s_reg.in_en_o <= ~hgfbm_pkg::RST_INPUT_DIS;
      s_reg.pd_en_o <= ~hgfbm_pkg::RST_PD_DIS & hgfbm_pkg::CTL_MASK;
    end else begin
      s_reg <= s_next;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************

  // All straight from the state register
  assign gpio_out = s_reg.pin_out;
  assign gpio_oe = s_reg.pin_oe;
  assign gpio_in_en = s_reg.in_en_o;
  assign gpio_pd_en = s_reg.pd_en_o;
  assign bc_slot_data = s_reg.bc_val;

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  // Right after reset all pins are inputs with pulldowns on except open-drain pin 3
  AST_RESET_INPUTS: assert property (
    $rose(arst_n) |-> (gpio_oe == 8'h00 && gpio_in_en == 8'hff && gpio_pd_en == 8'hf7))
    else $error("pins not inputs with pulldown after reset");

  // Open-drain pin keeps input on and pulldown off whatever is written
  AST_PIN3_FIXED: assert property (
    gpio_in_en[hgfbm_pkg::PIN_OD_IDX] && !gpio_pd_en[hgfbm_pkg::PIN_OD_IDX])
    else $error("open-drain pin controls changed");

  // Input control write shows on the enables one edge later
  AST_INPUT_WRITE: assert property (
    (reg_wr && reg_waddr == hgfbm_pkg::OFF_INPUT_EN) |=>
      (gpio_in_en == ~($past(reg_wdata) & hgfbm_pkg::CTL_MASK)))
    else $error("input enable did not follow write");

  // Pulldown write shows on the pulldown enables one edge later
  AST_PD_WRITE: assert property (
    (reg_wr && reg_waddr == hgfbm_pkg::OFF_PULLDOWN) |=>
      (gpio_pd_en == (~$past(reg_wdata) & hgfbm_pkg::CTL_MASK)))
    else $error("pulldown enable did not follow write");

  // Level register reads the pads as of the previous edge, any direction
  AST_LEVEL_READ: assert property (
    (reg_raddr == hgfbm_pkg::OFF_PIN_LEVEL) |-> (reg_rdata == $past(gpio_in)))
    else $error("pin level read wrong");

  // Pin 0 with output enable clear never drives
  AST_OE_OFF: assert property (
    !s_reg.out_ctl[0][hgfbm_pkg::OUT_EN_BIT] |-> !gpio_oe[0])
    else $error("pin driven while output disabled");

  // Pin 0 mapped to port 0 slot 0 follows the latched value within latency
  AST_FWD_LATENCY: assert property (
    (!reg_wr && s_reg.out_ctl[0] == 8'h01 && fwd_tick[0] && s_reg.frm[0] == 3'h0) |=>
      ##[0:2] (gpio_out[0] == $past(fwd_rx[0], 1) || gpio_out[0] == $past(fwd_rx[0], 2)))
    else $error("forward value late on pin");

  // Mid-period forward frames leave the latched values alone
  AST_FWD_HOLD: assert property (
    (fwd_tick[0] && s_reg.frm[0] != 3'h0) |=> $stable(s_reg.fwd_val[3:0]))
    else $error("forward value updated off cadence");

  // Frame counter never passes the period for three or four linked
  AST_FWD_PERIOD: assert property (
    (s_reg.fwd_cnt[0] >= 2'h2) |-> (s_reg.frm[0] < hgfbm_pkg::FWD_PERIOD_MANY))
    else $error("forward frame counter out of range");

  // Back slots change only when the thirty-bit frame wraps
  AST_BC_FRAME: assert property (
    !(bc_tick[0] && s_reg.bcbit[0] == hgfbm_pkg::BC_LAST_BIT) |=>
      $stable(bc_slot_data[3:0]))
    else $error("back slot changed mid frame");

  // Slot set to external frame sync carries it at the wrap
  AST_BC_EXT_FSYNC: assert property (
    (bc_tick[0] && s_reg.bcbit[0] == hgfbm_pkg::BC_LAST_BIT &&
     s_reg.bc_sel[0][3:0] == hgfbm_pkg::BC_SRC_EXT_FSYNC) |=> (bc_slot_data[0] == $past(fsync_ext)))
    else $error("external frame sync not sampled");

  // Input control reads back as the inverse of the enables
  AST_INPUT_READ: assert property (
    (reg_raddr == hgfbm_pkg::OFF_INPUT_EN) |-> (reg_rdata == ~gpio_in_en))
    else $error("input control readback wrong");

  // Pulldown control reads back as the inverse of the enables
  AST_PD_READ: assert property (
    (reg_raddr == hgfbm_pkg::OFF_PULLDOWN) |->
      (reg_rdata == (~gpio_pd_en & hgfbm_pkg::CTL_MASK)))
    else $error("pulldown control readback wrong");

  // Output control write sets a push-pull pin's enable one edge later
  AST_OUT_EN_WRITE: assert property (
    (reg_wr && reg_waddr >= hgfbm_pkg::OFF_OUT_CTL_FIRST &&
     reg_waddr <= hgfbm_pkg::OFF_OUT_CTL_LAST &&
     reg_waddr[hgfbm_pkg::PIN_IDX_W-1:0] != hgfbm_pkg::PIN_OD_IDX) |=>
      (gpio_oe[$past(reg_waddr[hgfbm_pkg::PIN_IDX_W-1:0])] ==
       $past(reg_wdata[hgfbm_pkg::OUT_EN_BIT])))
    else $error("output enable did not follow write");

  // One linked value: every frame latches the port's values
  AST_FWD_EVERY: assert property (
    (fwd_tick[0] && s_reg.fwd_cnt[0] == 2'h0 && s_reg.frm[0] == 3'h0) |=>
      (s_reg.fwd_val[3:0] == $past(fwd_rx[3:0])))
    else $error("forward value missed a frame");

  // Two linked values: the second frame closes the period
  AST_FWD_TWO: assert property (
    (fwd_tick[0] && s_reg.fwd_cnt[0] == 2'h1 && s_reg.frm[0] == 3'h1) |=>
      (s_reg.frm[0] == 3'h0))
    else $error("two-frame period not closed");

  // Back frame bit counter never passes the thirtieth bit
  AST_BC_COUNT: assert property (
    s_reg.bcbit[0] <= hgfbm_pkg::BC_LAST_BIT)
    else $error("back frame counter out of range");

  // Slot set to a pin carries its enabled level at the wrap
  AST_BC_PIN: assert property (
    (bc_tick[0] && s_reg.bcbit[0] == hgfbm_pkg::BC_LAST_BIT &&
     s_reg.bc_sel[0][7:4] <= hgfbm_pkg::BC_SRC_PIN_LAST) |=>
      (bc_slot_data[1] == $past(s_reg.pin_lvl[s_reg.bc_sel[0][6:4]] &
                                ~s_reg.in_dis[s_reg.bc_sel[0][6:4]])))
    else $error("pin not sampled into back slot");

  // Slot set to internal frame sync carries it at the wrap
  AST_BC_INT_FSYNC: assert property (
    (bc_tick[0] && s_reg.bcbit[0] == hgfbm_pkg::BC_LAST_BIT &&
     s_reg.bc_sel[0][11:8] == hgfbm_pkg::BC_SRC_INT_FSYNC) |=>
      (bc_slot_data[2] == $past(fsync_int)))
    else $error("internal frame sync not sampled");
endmodule
`default_nettype wire

// ### src/hgfbm_i2c_target.sv
// Two-wire target port: byte pointer, auto-increment register writes and reads
`timescale 1ns/10ps
`default_nettype none
module hgfbm_i2c_target #(
  parameter logic [6:0] DEV_ADDR = hgfbm_pkg::I2C_ADDR_DEFAULT
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic [7:0] reg_raddr,
  input wire logic [7:0] reg_rdata,
  output logic reg_wr,
  output logic [7:0] reg_waddr,
  output logic [7:0] reg_wdata
);
  typedef struct packed {
    logic scl_q;
    logic sda_q;
    hgfbm_pkg::hgfbm_i2c_e st;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [7:0] ptr;
    logic rdmode;
    logic after_addr;
    logic oe;
    logic wr;
    logic [7:0] waddr;
    logic [7:0] wdata;
  } hgfbm_i2c_s;
  hgfbm_i2c_s s_reg;
  hgfbm_i2c_s s_next;
  logic rise;
  logic fall;
  logic start;
  logic stop;

  // Bus edges and start/stop conditions
  assign rise = scl_in & ~s_reg.scl_q;
  assign fall = ~scl_in & s_reg.scl_q;
  assign start = s_reg.scl_q & scl_in & s_reg.sda_q & ~sda_in;
  assign stop = s_reg.scl_q & scl_in & ~s_reg.sda_q & sda_in;

  // Byte engine; ack is driven from the falling edge so data is stable at rise
  always_comb begin
    s_next = s_reg;
    s_next.scl_q = scl_in;
    s_next.sda_q = sda_in;
    s_next.wr = 1'b0;
    if (start) begin
      s_next.st = hgfbm_pkg::HGFBM_ADDR;
      s_next.cnt = '0;
      s_next.oe = 1'b0;
    end else if (stop) begin
      s_next.st = hgfbm_pkg::HGFBM_IDLE;
      s_next.oe = 1'b0;
    end else begin
      case (s_reg.st)
        hgfbm_pkg::HGFBM_ADDR, hgfbm_pkg::HGFBM_PTR, hgfbm_pkg::HGFBM_WDATA: begin
          if (rise && s_reg.cnt < hgfbm_pkg::BYTE_BITS) begin
            s_next.sh = {s_reg.sh[6:0], sda_in};
            s_next.cnt = 4'(s_reg.cnt + 4'h1);
          end
          if (fall && s_reg.cnt == hgfbm_pkg::BYTE_BITS) begin
            s_next.cnt = '0;
            s_next.st = hgfbm_pkg::HGFBM_ACK;
            s_next.oe = 1'b1;
            s_next.after_addr = 1'b0;
            if (s_reg.st == hgfbm_pkg::HGFBM_ADDR) begin
              s_next.rdmode = s_reg.sh[0];
              s_next.after_addr = 1'b1;
              if (s_reg.sh[7:1] != DEV_ADDR) begin
                s_next.st = hgfbm_pkg::HGFBM_IDLE;
                s_next.oe = 1'b0;
              end
            end else if (s_reg.st == hgfbm_pkg::HGFBM_PTR) begin
              s_next.ptr = s_reg.sh;
            end else begin
              s_next.wr = 1'b1;
              s_next.waddr = s_reg.ptr;
              s_next.wdata = s_reg.sh;
              s_next.ptr = 8'(s_reg.ptr + 8'h01);
            end
          end
        end
        hgfbm_pkg::HGFBM_ACK: begin
          if (fall) begin
            s_next.oe = 1'b0;
            s_next.cnt = '0;
            if (s_reg.rdmode) begin
              s_next.sh = reg_rdata;
              s_next.oe = ~reg_rdata[7];
              s_next.cnt = 4'h1;
              s_next.ptr = 8'(s_reg.ptr + 8'h01);
              s_next.st = hgfbm_pkg::HGFBM_RDATA;
            end else if (s_reg.after_addr) begin
              s_next.st = hgfbm_pkg::HGFBM_PTR;
            end else begin
              s_next.st = hgfbm_pkg::HGFBM_WDATA;
            end
          end
        end
        hgfbm_pkg::HGFBM_RDATA: begin
          if (fall && s_reg.cnt < hgfbm_pkg::BYTE_BITS) begin
            s_next.oe = ~s_reg.sh[6];
            s_next.sh = {s_reg.sh[6:0], 1'b0};
            s_next.cnt = 4'(s_reg.cnt + 4'h1);
          end else if (fall) begin
            s_next.oe = 1'b0;
            s_next.st = hgfbm_pkg::HGFBM_RACK;
          end
        end
        hgfbm_pkg::HGFBM_RACK: begin
          if (rise) begin
            s_next.st = sda_in ? hgfbm_pkg::HGFBM_IDLE : hgfbm_pkg::HGFBM_ACK;
          end
        end
        default: begin
          s_next.oe = 1'b0;
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_reg <= '0;
      s_reg.scl_q <= 1'b1;
      s_reg.sda_q <= 1'b1;
      s_reg.st <= hgfbm_pkg::HGFBM_IDLE;
    end else begin
      s_reg <= s_next;
    end
  end

  // Open drain: only ever pulls low
  assign sda_out = 1'b0;
  assign sda_oe = s_reg.oe;
  assign reg_raddr = s_reg.ptr;
  assign reg_wr = s_reg.wr;
  assign reg_waddr = s_reg.waddr;
  assign reg_wdata = s_reg.wdata;
endmodule
`default_nettype wire
